// ==== port_g_pkg.sv ====
// Purpose: shared constants of the eight-line general purpose port
// Assumes: 32-bit APB data, one register per aligned word
// Notes: offsets are byte addresses inside the port window

package port_g_pkg;

  localparam int LINES = 8;

  // bus window
  localparam logic [31:0] PORT_BASE_ADDR = 32'h4000_0180;
  localparam int WIN_LSB = 6;
  localparam int OFS_W = 6;

  // register offsets
  localparam logic [5:0] OFS_PIN_DATA = 6'h00;
  localparam logic [5:0] OFS_OUTPUT_ENABLE = 6'h04;
  localparam logic [5:0] OFS_FUNCTION_ONE = 6'h08;
  localparam logic [5:0] OFS_RESERVED = 6'h10;
  localparam logic [5:0] OFS_OPEN_DRAIN = 6'h28;
  localparam logic [5:0] OFS_PULLUP = 6'h2c;
  localparam logic [5:0] OFS_INPUT_ENABLE = 6'h38;

  // reset values and unused upper bits
  localparam logic [7:0] LINE_RESET = 8'h00;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // function select bit positions
  localparam int FN_SERIAL_ZERO_OUT = 0;
  localparam int FN_SERIAL_ZERO_IN = 1;
  localparam int FN_SERIAL_ZERO_CLK = 2;
  localparam int FN_EXT_INT_FOUR = 3;
  localparam int FN_SERIAL_TWO_OUT = 4;
  localparam int FN_SERIAL_TWO_IN = 5;
  localparam int FN_SERIAL_TWO_CLK = 6;
  localparam int FN_TIMER_EIGHT = 7;

  // lines whose alternate function is input only
  localparam logic [7:0] INPUT_ONLY_LINES = 8'h08;

endpackage

// ==== pin_sync3.sv ====
// Purpose: three flip-flop synchroniser for one pin input
// Assumes: pin changes slowly compared with the clock
// Notes: a new level is accepted once stages two and three agree

`timescale 1ns/10ps

module pin_sync3 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  logic stage1_ff;
  logic stage2_ff;
  logic stage3_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
    end else begin
      stage1_ff <= pin_i;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (stage2_ff == stage3_ff) begin
      level_o <= stage3_ff;
    end
  end

endmodule

// ==== line_drive_cell.sv ====
// Purpose: drive decision for one port line
// Assumes: alternate peripheral supplies its own value and drive request
// Notes: purely combinational, the top registers the result

`timescale 1ns/10ps

module line_drive_cell (
  input wire logic port_val_i,
  input wire logic out_en_i,
  input wire logic open_drain_i,
  input wire logic alt_sel_i,
  input wire logic alt_val_i,
  input wire logic alt_oe_i,
  input wire logic input_only_i,
  input wire logic pins_off_i,
  output logic drive_val_o,
  output logic drive_oe_n_o
);

  logic val;
  logic en;

  always_comb begin
    val = alt_sel_i ? alt_val_i : port_val_i;
    en = out_en_i & ~pins_off_i & ~(alt_sel_i & input_only_i) & (~alt_sel_i | alt_oe_i);
    // open drain only ever pulls low, the pull-up or bus gives the high
    drive_val_o = open_drain_i ? 1'b0 : val;
    drive_oe_n_o = ~(en & (~open_drain_i | ~val));
  end

endmodule

// ==== port_g_gpio.sv ====
// Purpose: eight-line general purpose port with alternate functions on APB
// Assumes: stop mode and standby drive control come from the same clock domain
// Notes: one wait state on every APB access; pins pass a three-stage synchroniser
//
// Implementation choice: register access over APB.

`timescale 1ns/10ps

module port_g_gpio
  import port_g_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] PIN_I,
  output logic [7:0] PIN_O,
  output logic [7:0] PIN_OE_N_O,
  output logic [7:0] PULLUP_EN_O,
  input wire logic [7:0] ALT_OUT_I,
  input wire logic [7:0] ALT_OE_I,
  output logic [7:0] ALT_IN_O,
  output logic EXT_INT_FOUR_O,
  input wire logic STOP_MODE_I,
  input wire logic PIN_DRIVE_IN_STANDBY_I
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] pin_data_ff;
  logic [7:0] output_enable_ff;
  logic [7:0] function_one_ff;
  logic [7:0] open_drain_ff;
  logic [7:0] pullup_ff;
  logic [7:0] input_enable_ff;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [OFS_W-1:0] offset;
  logic win_hit;
  logic reg_hit;
  logic access_phase;
  logic wr_commit;
  logic [31:0] nxt_rdata;

  assign offset = PADDR_I[OFS_W-1:0];
  assign win_hit = (PADDR_I[31:WIN_LSB] == PORT_BASE_ADDR[31:WIN_LSB]);
  // the reserved word and every hole answer with an error, nothing stored
  assign reg_hit = win_hit && ((offset == OFS_PIN_DATA) || (offset == OFS_OUTPUT_ENABLE) ||
                   (offset == OFS_FUNCTION_ONE) || (offset == OFS_OPEN_DRAIN) ||
                   (offset == OFS_PULLUP) || (offset == OFS_INPUT_ENABLE));
  assign access_phase = PSEL_I & PENABLE_I;
  assign wr_commit = access_phase & PREADY_O & PWRITE_I & reg_hit;

  logic [7:0] pin_level;
  logic [7:0] data_view;

  // lines read as inputs show the pin, driven lines show the latch
  assign data_view = (input_enable_ff & ~output_enable_ff & pin_level) |
                     (~(input_enable_ff & ~output_enable_ff) & pin_data_ff);

  always_comb begin
    nxt_rdata = WORD_ZERO;
    if (win_hit) begin
      case (offset)
        OFS_PIN_DATA: nxt_rdata = {UPPER_ZERO, data_view};
        OFS_OUTPUT_ENABLE: nxt_rdata = {UPPER_ZERO, output_enable_ff};
        OFS_FUNCTION_ONE: nxt_rdata = {UPPER_ZERO, function_one_ff};
        OFS_OPEN_DRAIN: nxt_rdata = {UPPER_ZERO, open_drain_ff};
        OFS_PULLUP: nxt_rdata = {UPPER_ZERO, pullup_ff};
        OFS_INPUT_ENABLE: nxt_rdata = {UPPER_ZERO, input_enable_ff};
        default: nxt_rdata = WORD_ZERO;
      endcase
    end
  end

  // one wait state: ready rises in the second access cycle, drops after
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= WORD_ZERO;
    end else if (access_phase && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= ~reg_hit;
      PRDATA_O <= PWRITE_I ? WORD_ZERO : nxt_rdata;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= WORD_ZERO;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_data_ff <= LINE_RESET;
      output_enable_ff <= LINE_RESET;
      function_one_ff <= LINE_RESET;
      open_drain_ff <= LINE_RESET;
      pullup_ff <= LINE_RESET;
      input_enable_ff <= LINE_RESET;
    end else if (wr_commit) begin
      case (offset)
        OFS_PIN_DATA: pin_data_ff <= PWDATA_I[7:0];
        OFS_OUTPUT_ENABLE: output_enable_ff <= PWDATA_I[7:0];
        OFS_FUNCTION_ONE: function_one_ff <= PWDATA_I[7:0];
        OFS_OPEN_DRAIN: open_drain_ff <= PWDATA_I[7:0];
        OFS_PULLUP: pullup_ff <= PWDATA_I[7:0];
        OFS_INPUT_ENABLE: input_enable_ff <= PWDATA_I[7:0];
        default: pin_data_ff <= pin_data_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin side

  logic pins_off;
  logic [7:0] nxt_pin;
  logic [7:0] nxt_oe_n;
  logic input_open;
  logic nxt_ext_int;

  // standby drive control cuts pins only inside stop
  assign pins_off = STOP_MODE_I & ~PIN_DRIVE_IN_STANDBY_I;
  assign input_open = ~pins_off;

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      pin_sync3 u_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_n),
        .pin_i(PIN_I[gi]),
        .level_o(pin_level[gi])
      );
      line_drive_cell u_drive (
        .port_val_i(pin_data_ff[gi]),
        .out_en_i(output_enable_ff[gi]),
        .open_drain_i(open_drain_ff[gi]),
        .alt_sel_i(function_one_ff[gi]),
        .alt_val_i(ALT_OUT_I[gi]),
        .alt_oe_i(ALT_OE_I[gi]),
        .input_only_i(INPUT_ONLY_LINES[gi]),
        .pins_off_i(pins_off),
        .drive_val_o(nxt_pin[gi]),
        .drive_oe_n_o(nxt_oe_n[gi])
      );
    end
  endgenerate

  // function bits choose the port latch or the peripheral output per line
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PIN_O <= LINE_RESET;
      PIN_OE_N_O <= ~LINE_RESET;
    end else begin
      PIN_O <= nxt_pin;
      PIN_OE_N_O <= nxt_oe_n;
    end
  end

  // pull-ups follow the register in every mode; pins_off does not release them in stop
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PULLUP_EN_O <= LINE_RESET;
    end else begin
      PULLUP_EN_O <= pullup_ff;
    end
  end

  // peripherals see a line only when its input path is open
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ALT_IN_O <= LINE_RESET;
    end else begin
      ALT_IN_O <= pin_level & input_enable_ff & function_one_ff & {LINES{input_open}};
    end
  end

  // interrupt path ignores the function bit unless pins_off; users must mask
  always_comb begin
    if (!STOP_MODE_I) begin
      nxt_ext_int = pin_level[FN_EXT_INT_FOUR] & input_enable_ff[FN_EXT_INT_FOUR];
    end else if (pins_off) begin
      nxt_ext_int = pin_level[FN_EXT_INT_FOUR] & input_enable_ff[FN_EXT_INT_FOUR] &
                    function_one_ff[FN_EXT_INT_FOUR];
    end else begin
      nxt_ext_int = pin_level[FN_EXT_INT_FOUR] & input_enable_ff[FN_EXT_INT_FOUR];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      EXT_INT_FOUR_O <= 1'b0;
    end else begin
      EXT_INT_FOUR_O <= nxt_ext_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!rst_n);

  a_reset_port_state: assert property (
    $rose(rst_n) |-> (function_one_ff == LINE_RESET) && (output_enable_ff == LINE_RESET) &&
      (pullup_ff == LINE_RESET) && (input_enable_ff == LINE_RESET))
    else $error("port not in plain function after reset");

  a_data_write_lands: assert property (
    (wr_commit && offset == OFS_PIN_DATA) |=> pin_data_ff == $past(PWDATA_I[7:0]))
    else $error("data register missed a write");

  a_read_upper_zero: assert property (
    PREADY_O |-> PRDATA_O[31:8] == UPPER_ZERO)
    else $error("upper read bits not zero");

  a_read_oe_map: assert property (
    (access_phase && !PREADY_O && !PWRITE_I && win_hit && offset == OFS_OUTPUT_ENABLE)
      |=> PREADY_O && !PSLVERR_O && PRDATA_O[7:0] == $past(output_enable_ff))
    else $error("output enable read wrong");

  a_reserved_error: assert property (
    (access_phase && !PREADY_O && win_hit && offset == OFS_RESERVED)
      |=> PREADY_O && PSLVERR_O)
    else $error("reserved slot not refused");

  a_pullup_follows: assert property (
    (wr_commit && offset == OFS_PULLUP) |-> ##2 PULLUP_EN_O == $past(PWDATA_I[7:0], 2))
    else $error("pull-up output lagging write");

  a_no_drive_off: assert property (
    (!output_enable_ff[0]) |=> PIN_OE_N_O[0])
    else $error("line driven with output disabled");

  a_open_drain_high: assert property (
    (open_drain_ff[1] && !function_one_ff[1] && pin_data_ff[1]) |=> PIN_OE_N_O[1])
    else $error("open drain drove a high");

  a_int_pin_input: assert property (
    function_one_ff[FN_EXT_INT_FOUR] |=> PIN_OE_N_O[FN_EXT_INT_FOUR])
    else $error("interrupt line driven");

  a_timer_route: assert property (
    (function_one_ff[FN_TIMER_EIGHT] && output_enable_ff[FN_TIMER_EIGHT] &&
      !open_drain_ff[FN_TIMER_EIGHT] && !pins_off)
      |=> PIN_O[FN_TIMER_EIGHT] == $past(ALT_OUT_I[FN_TIMER_EIGHT]))
    else $error("timer output not routed");

  a_int_run_mode: assert property (
    (!STOP_MODE_I && input_enable_ff[FN_EXT_INT_FOUR])
      |=> EXT_INT_FOUR_O == $past(pin_level[FN_EXT_INT_FOUR]))
    else $error("interrupt not following pin");

  a_int_stop_wake: assert property (
    (pins_off && input_enable_ff[FN_EXT_INT_FOUR] && function_one_ff[FN_EXT_INT_FOUR])
      |=> EXT_INT_FOUR_O == $past(pin_level[FN_EXT_INT_FOUR]))
    else $error("stop wake path closed");

  a_input_blocked: assert property (
    !input_enable_ff[5] |=> !ALT_IN_O[5])
    else $error("blocked input reached peripheral");

  a_window_refused: assert property (
    (access_phase && !PREADY_O && !win_hit) |=> PREADY_O && PSLVERR_O)
    else $error("access outside window not refused");

  a_oe_write_lands: assert property (
    (wr_commit && offset == OFS_OUTPUT_ENABLE) |=> output_enable_ff == $past(PWDATA_I[7:0]))
    else $error("output enable register missed a write");

  a_func_write_lands: assert property (
    (wr_commit && offset == OFS_FUNCTION_ONE) |=> function_one_ff == $past(PWDATA_I[7:0]))
    else $error("function register missed a write");

  a_od_write_lands: assert property (
    (wr_commit && offset == OFS_OPEN_DRAIN) |=> open_drain_ff == $past(PWDATA_I[7:0]))
    else $error("open drain register missed a write");

  a_ie_write_lands: assert property (
    (wr_commit && offset == OFS_INPUT_ENABLE) |=> input_enable_ff == $past(PWDATA_I[7:0]))
    else $error("input enable register missed a write");

  a_refused_no_store: assert property (
    (access_phase && PREADY_O && !reg_hit) |=> $stable(pin_data_ff) && $stable(output_enable_ff) &&
      $stable(function_one_ff) && $stable(input_enable_ff))
    else $error("refused access changed a register");

  a_stop_no_drive: assert property (
    pins_off |=> PIN_OE_N_O == ~LINE_RESET)
    else $error("pin driven while pads are off");

  a_stop_input_closed: assert property (
    pins_off |=> ALT_IN_O == LINE_RESET)
    else $error("peripheral input open while pads are off");

  a_read_idle_zero: assert property (
    !PREADY_O |-> PRDATA_O == WORD_ZERO)
    else $error("read data not zero outside answer");

  c_write_done: cover property (wr_commit);
  c_reserved_hit: cover property (PREADY_O && PSLVERR_O);
  c_stop_wake: cover property (pins_off && $rose(EXT_INT_FOUR_O));
  c_open_drain_low: cover property (open_drain_ff[0] && !PIN_OE_N_O[0]);

endmodule

// ==== pad_far_model.sv ====
// Purpose: pads and far-side drivers of the eight port lines
// Assumes: bench drives a line only where the port leaves it free
// Notes: a free line without pull-up toggles every cycle
`timescale 1ns/10ps
module pad_far_model (
  input wire logic clk_i,
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  logic [7:0] float_ff = 8'h55;
  // a floating pad must never settle to a convenient level
  always @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i])
        level_o[i] = pin_o_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_val_i[i];
      else if (pullup_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = float_ff[i];
    end
  end
endmodule

// ==== port_g_gpio_test.sv ====
// Purpose: self-checking bench of the eight-line port
// Assumes: one wait state per bus access, about five edges pin latency
// Notes: pads come from the far-side model
`timescale 1ns/10ps
module port_g_gpio_test;
  import port_g_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] padr = 32'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic [7:0] lvl;
  logic [7:0] pin_o;
  logic [7:0] oe_n;
  logic [7:0] pu;
  logic [7:0] alt_out = 8'h00;
  logic [7:0] alt_oe = 8'h00;
  logic [7:0] alt_in;
  logic ext_int;
  logic stop = 1'b0;
  logic drv = 1'b1;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [5:0] regs [6] = '{OFS_PIN_DATA, OFS_OUTPUT_ENABLE, OFS_FUNCTION_ONE,
    OFS_OPEN_DRAIN, OFS_PULLUP, OFS_INPUT_ENABLE};

  always #4 clk = ~clk;

  port_g_gpio u_port_g_gpio (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .PIN_I(lvl), .PIN_O(pin_o), .PIN_OE_N_O(oe_n),
    .PULLUP_EN_O(pu), .ALT_OUT_I(alt_out), .ALT_OE_I(alt_oe), .ALT_IN_O(alt_in),
    .EXT_INT_FOUR_O(ext_int), .STOP_MODE_I(stop), .PIN_DRIVE_IN_STANDBY_I(drv));
  pad_far_model u_pad_far_model (.clk_i(clk), .pin_o_i(pin_o), .oe_n_i(oe_n),
    .pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  // request held until pready is sampled high, answer taken at that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk("pready", 1'b1, prdy);
  endtask

  task automatic wr(input logic [5:0] o, input logic [31:0] d);
    apb(1'b1, PORT_BASE_ADDR + 32'(o), d);
  endtask

  task automatic rd_chk(input logic [5:0] o, input logic [31:0] exp);
    apb(1'b0, PORT_BASE_ADDR + 32'(o), 32'h0);
    chk("read data", exp, rd);
    chk("read error", 1'b0, err);
  endtask

  // ends on a rising edge so the next stimulus is launched there
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  task automatic clear_all;
    foreach (regs[i]) wr(regs[i], 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    chk("oe_n", 8'hff, oe_n);
    chk("pullup", 8'h00, pu);
    chk("alt_in", 8'h00, alt_in);
    chk("ext_int", 1'b0, ext_int);
    $display("test reset done");
  endtask

  task automatic t_regs;
    // input enable kept inside output enable so data reads the stored bits
    logic [7:0] v [6] = '{8'h3c, 8'h5a, 8'hc3, 8'h96, 8'h81, 8'h42};
    foreach (regs[i]) wr(regs[i], {24'hffffff, v[i]});
    foreach (regs[i]) rd_chk(regs[i], {24'h0, v[i]});
    clear_all();
    $display("test registers done");
  endtask

  task automatic t_refuse;
    logic [31:0] bad [4] = '{PORT_BASE_ADDR + 32'h10, PORT_BASE_ADDR + 32'h2,
      PORT_BASE_ADDR + 32'h40, PORT_BASE_ADDR - 32'h4};
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hff);
      chk("write error", 1'b1, err);
      apb(1'b0, bad[i], 32'h0);
      chk("refused data", 32'h0, rd);
      chk("read refused error", 1'b1, err);
    end
    rd_chk(OFS_PIN_DATA, 32'h0);
    $display("test refused done");
  endtask

  task automatic t_drive;
    wr(OFS_OUTPUT_ENABLE, 32'h0f);
    wr(OFS_PIN_DATA, 32'h05);
    settle();
    chk("oe_n", 8'hf0, oe_n);
    chk("pin_o", 8'h05, pin_o & 8'h0f);
    wr(OFS_OPEN_DRAIN, 32'h01);
    settle();
    chk("od high oe_n", 8'hf1, oe_n);
    wr(OFS_PIN_DATA, 32'h04);
    settle();
    chk("od low oe_n", 8'hf0, oe_n);
    chk("od low pin", 1'b0, pin_o[0]);
    clear_all();
    $display("test drive done");
  endtask

  task automatic t_input;
    ext_en <= 8'h02;
    ext_val <= 8'h02;
    wr(OFS_PULLUP, 32'h81);
    wr(OFS_INPUT_ENABLE, 32'h83);
    settle();
    chk("pullup", 8'h81, pu);
    rd_chk(OFS_PIN_DATA, 32'h83);
    wr(OFS_INPUT_ENABLE, 32'h0);
    rd_chk(OFS_PIN_DATA, 32'h0);
    clear_all();
    ext_en <= 8'h00;
    $display("test input done");
  endtask

  task automatic t_alt;
    alt_out <= 8'ha5;
    alt_oe <= 8'hff;
    wr(OFS_OUTPUT_ENABLE, 32'hff);
    wr(OFS_PIN_DATA, 32'h08);
    wr(OFS_FUNCTION_ONE, 32'hf7);
    wr(OFS_INPUT_ENABLE, 32'hff);
    settle();
    chk("alt oe_n", 8'h00, oe_n);
    chk("alt pin_o", 8'had, pin_o);
    chk("alt_in", 8'ha5, alt_in);
    chk("alt int", 1'b1, ext_int);
    alt_oe <= 8'h00;
    settle();
    chk("alt idle oe_n", 8'hf7, oe_n);
    clear_all();
    $display("test alternate done");
  endtask

  task automatic t_int;
    ext_en <= 8'h08;
    ext_val <= 8'h08;
    wr(OFS_INPUT_ENABLE, 32'h08);
    settle();
    chk("int run", 1'b1, ext_int);
    stop <= 1'b1;
    drv <= 1'b0;
    settle();
    chk("int stop port", 1'b0, ext_int);
    wr(OFS_FUNCTION_ONE, 32'h08);
    settle();
    chk("int stop", 1'b1, ext_int);
    chk("stop alt_in", 8'h00, alt_in);
    chk("stop oe_n", 8'hff, oe_n);
    ext_val <= 8'h00;
    settle();
    chk("int stop low", 1'b0, ext_int);
    stop <= 1'b0;
    drv <= 1'b1;
    clear_all();
    ext_en <= 8'h00;
    $display("test interrupt done");
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_refuse();
    t_drive();
    t_input();
    t_alt();
    t_int();
    finish_test();
  end

  // whole run is a few hundred cycles
  initial begin
    #(8 * 20000);
    n_mismatch++;
    finish_test();
  end
endmodule
